// ### design/ppi_cfg.svh
`ifndef PPI_CFG_SVH
`define PPI_CFG_SVH

// Register offsets on the host port
`define OFS_PORT_A 3'h0
`define OFS_PORT_B 3'h1
`define OFS_PORT_C 3'h2
`define OFS_CTRL 3'h3
`define OFS_IRQ_STAT 3'h4
`define OFS_IRQ_CLR 3'h5
`define OFS_IRQ_EN 3'h6

// Control word fields
`define CW_FLAG 7
`define CW_AMODE_HI 6
`define CW_AMODE_LO 5
`define CW_A_IN 4
`define CW_CU_IN 3
`define CW_B_MODE 2
`define CW_B_IN 1
`define CW_CL_IN 0
`define AMODE_BASIC 2'h0
`define AMODE_STROBED 2'h1
`define BSR_IDX_HI 3
`define BSR_IDX_LO 1
`define BSR_VAL 0

// Control word values
`define ALL_OUT_WORD 8'h80
`define ALL_IN_WORD 8'h9B
`define A_IN_WORD 8'h90
`define CTRL_RESET `ALL_IN_WORD

// Port C handshake line positions
`define PC_INTR_B 0
`define PC_BUF_B 1
`define PC_STB_B 2
`define PC_INTR_A 3
`define PC_STB_A 4
`define PC_IBF_A 5
`define PC_ACK_A 6
`define PC_OBF_A 7
`define NIBBLE_W 4

// Sticky interrupt status layout
`define IRQ_W 2
`define IRQ_A 0
`define IRQ_B 1

`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hFF

`endif

// ### design/ppi_pkg.sv
package ppi_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {GM_BASIC, GM_STROBED, GM_BIDIR} grpMode_t;
endpackage

// ### design/sync_two_ff.sv
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 24
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // Refuse a width that has no bits
    if (WIDTH < 1) begin : gBad
        $error("sync_two_ff needs WIDTH of at least 1");
    end

    // Two stages; only the second stage is seen outside
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '1;
            dout <= '1;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // sync_two_ff
`default_nettype wire

// ### design/hs_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppi_cfg.svh"
module hs_channel (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic inEn,
    input wire logic outEn,
    input wire logic stbN,
    input wire logic ackN,
    input wire ppi_pkg::byte_t pinData,
    input wire logic hostRd,
    input wire logic hostWr,
    input wire logic inteIn,
    input wire logic inteOut,
    input wire logic clrAll,
    output ppi_pkg::byte_t inData,
    output logic ibf,
    output logic obfN,
    output logic intr
);
    import ppi_pkg::*;

    logic stbPrev_q;
    logic ackPrev_q;
    logic intrIn_q;
    logic intrOut_q;
    logic stbFall;
    logic stbRise;
    logic ackFall;
    logic ackRise;

    // Edges of the synchronised strobe and acknowledge
    assign stbFall = inEn & stbPrev_q & ~stbN;
    assign stbRise = inEn & ~stbPrev_q & stbN;
    assign ackFall = outEn & ackPrev_q & ~ackN;
    assign ackRise = outEn & ~ackPrev_q & ackN;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stbPrev_q <= 1'b1;
            ackPrev_q <= 1'b1;
        end else begin
            stbPrev_q <= stbN;
            ackPrev_q <= ackN;
        end
    end

    // Input latch and buffer-full; strobe wins over host read
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inData <= `BYTE_ZERO;
            ibf <= 1'b0;
        end else if (stbFall) begin
            inData <= pinData;
            ibf <= 1'b1;
        end else if (hostRd | clrAll | ~inEn) begin
            ibf <= 1'b0;
        end
    end

    // Output buffer full (active low); host write wins over ack
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            obfN <= 1'b1;
        end else if (hostWr & outEn) begin
            obfN <= 1'b0;
        end else if (ackFall | clrAll | ~outEn) begin
            obfN <= 1'b1;
        end
    end

    // Request flags; the setting edge wins over the host access
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            intrIn_q <= 1'b0;
            intrOut_q <= 1'b0;
        end else begin
            if (stbRise & ibf) begin
                intrIn_q <= 1'b1;
            end else if (hostRd | clrAll) begin
                intrIn_q <= 1'b0;
            end
            if (ackRise & obfN) begin
                intrOut_q <= 1'b1;
            end else if (hostWr | clrAll) begin
                intrOut_q <= 1'b0;
            end
        end
    end

    // Each request gated by its own enable
    assign intr = (intrIn_q & inteIn) | (intrOut_q & inteOut);

    strobe_latch_a: assert property (@(posedge mclk) disable iff (!arst_n)
        stbFall |=> ibf && inData == $past(pinData))
        else $error("strobe did not latch input data");
    req_raise_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (stbRise && ibf) || (ackRise && obfN)
        |=> intrIn_q || intrOut_q)
        else $error("handshake edge did not raise a request");
endmodule // hs_channel
`default_nettype wire

// ### design/programmable_parallel_io.sv
// What this block does
// - Twenty-four lines as three byte ports A, B and C.
// - First group: port A plus port C lines 4 to 7.
// - Second group: port B plus port C lines 0 to 3.
// - Modes: basic I/O, strobed handshake, bidirectional bus.
// - Basic mode moves data on register access, no handshake.
// - Basic mode latches outputs; input reads show live pin state.
// - Basic mode: A, B, C upper, C lower each pick direction.
// - Strobed mode pairs data port with C nibble; data latched.
// - Strobed mode requests per port, each with its own enable.
// - Bus mode, first group only: A bidirectional, five C lines.
// - One control word sets or clears one port C line alone.
// - Flag bit one: bits 6..0 carry modes and directions.
// - Flag bit zero: bits 3..0 carry a port C set/reset.
// - Sixteen basic layouts; 80 all out, 9B all in.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ppi_cfg.svh"
module programmable_parallel_io (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [2:0] addr,
    input wire ppi_pkg::byte_t wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output ppi_pkg::byte_t rdData,
    input wire ppi_pkg::byte_t paIn,
    output ppi_pkg::byte_t paOut,
    output ppi_pkg::byte_t paOe,
    input wire ppi_pkg::byte_t pbIn,
    output ppi_pkg::byte_t pbOut,
    output ppi_pkg::byte_t pbOe,
    input wire ppi_pkg::byte_t pcIn,
    output ppi_pkg::byte_t pcOut,
    output ppi_pkg::byte_t pcOe,
    output logic irq
);
    import ppi_pkg::*;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    logic [23:0] pinSync;
    byte_t paSync;
    byte_t pbSync;
    byte_t pcSync;
    byte_t portModeCtrl_q;
    byte_t aOut_q;
    byte_t bOut_q;
    byte_t pcLatch_q;
    byte_t aInLatch;
    byte_t bInLatch;
    byte_t hsOutMask;
    byte_t hsInMask;
    byte_t hsVal;
    byte_t pcRead;
    byte_t paRead;
    byte_t pbRead;
    grpMode_t aMode;
    grpMode_t bMode;
    logic aIn;
    logic bIn;
    logic aHsIn;
    logic aHsOut;
    logic bHsIn;
    logic bHsOut;
    logic ibfA;
    logic ibfB;
    logic obfAN;
    logic obfBN;
    logic intrA;
    logic intrB;
    logic wrCtrl;
    logic wrMode;
    logic wrBit;
    logic wrA;
    logic wrB;
    logic wrC;
    logic rdA;
    logic rdB;
    logic [2:0] bitIdx;
    logic [`IRQ_W-1:0] irqStat_q;
    logic [`IRQ_W-1:0] irqEn_q;
    logic [`IRQ_W-1:0] intrPrev_q;
    logic [`IRQ_W-1:0] irqEvt;

    // All pin inputs pass two flops first
    sync_two_ff #(.WIDTH(24)) uSync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din({pcIn, pbIn, paIn}),
        .dout(pinSync)
    );
    assign paSync = pinSync[7:0];
    assign pbSync = pinSync[15:8];
    assign pcSync = pinSync[23:16];

    // Host access decode
    assign wrCtrl = wrStb && addr == `OFS_CTRL;
    assign wrMode = wrCtrl & wrData[`CW_FLAG];
    assign wrBit = wrCtrl & ~wrData[`CW_FLAG];
    assign wrA = wrStb && addr == `OFS_PORT_A;
    assign wrB = wrStb && addr == `OFS_PORT_B;
    assign wrC = wrStb && addr == `OFS_PORT_C;
    assign rdA = rdStb && addr == `OFS_PORT_A;
    assign rdB = rdStb && addr == `OFS_PORT_B;
    assign bitIdx = wrData[`BSR_IDX_HI:`BSR_IDX_LO];

    // Mode and direction word; only flagged words land here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            portModeCtrl_q <= `CTRL_RESET;
        end else if (wrMode) begin
            portModeCtrl_q <= wrData;
        end
    end

    // Group mode decode
    always_comb begin
        case (portModeCtrl_q[`CW_AMODE_HI:`CW_AMODE_LO])
            `AMODE_BASIC: aMode = GM_BASIC;
            `AMODE_STROBED: aMode = GM_STROBED;
            default: aMode = GM_BIDIR;
        endcase
        bMode = portModeCtrl_q[`CW_B_MODE] ? GM_STROBED : GM_BASIC;
    end
    assign aIn = portModeCtrl_q[`CW_A_IN];
    assign bIn = portModeCtrl_q[`CW_B_IN];

    // Handshake roles of each data port
    assign aHsIn = (aMode == GM_STROBED && aIn) || aMode == GM_BIDIR;
    assign aHsOut = (aMode == GM_STROBED && !aIn) || aMode == GM_BIDIR;
    assign bHsIn = bMode == GM_STROBED && bIn;
    assign bHsOut = bMode == GM_STROBED && !bIn;

    // Port A output latch; a new mode word clears it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            aOut_q <= `BYTE_ZERO;
        end else if (wrMode) begin
            aOut_q <= `BYTE_ZERO;
        end else if (wrA) begin
            aOut_q <= wrData;
        end
    end

    // Port B output latch
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bOut_q <= `BYTE_ZERO;
        end else if (wrMode) begin
            bOut_q <= `BYTE_ZERO;
        end else if (wrB) begin
            bOut_q <= wrData;
        end
    end

    // Port C latch; also holds the handshake interrupt enables
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pcLatch_q <= `BYTE_ZERO;
        end else if (wrMode) begin
            pcLatch_q <= `BYTE_ZERO;
        end else if (wrBit) begin
            pcLatch_q[bitIdx] <= wrData[`BSR_VAL];
        end else if (wrC) begin
            pcLatch_q <= wrData;
        end
    end

    // Group one handshake: strobe C4, ack C6, enables C4/C6
    hs_channel uHsA (
        .mclk(mclk),
        .arst_n(arst_n),
        .inEn(aHsIn),
        .outEn(aHsOut),
        .stbN(pcSync[`PC_STB_A]),
        .ackN(pcSync[`PC_ACK_A]),
        .pinData(paSync),
        .hostRd(rdA),
        .hostWr(wrA),
        .inteIn(pcLatch_q[`PC_STB_A]),
        .inteOut(pcLatch_q[`PC_ACK_A]),
        .clrAll(wrMode),
        .inData(aInLatch),
        .ibf(ibfA),
        .obfN(obfAN),
        .intr(intrA)
    );

    // Group two handshake: C2 is strobe or ack, and its enable
    hs_channel uHsB (
        .mclk(mclk),
        .arst_n(arst_n),
        .inEn(bHsIn),
        .outEn(bHsOut),
        .stbN(pcSync[`PC_STB_B]),
        .ackN(pcSync[`PC_STB_B]),
        .pinData(pbSync),
        .hostRd(rdB),
        .hostWr(wrB),
        .inteIn(pcLatch_q[`PC_STB_B]),
        .inteOut(pcLatch_q[`PC_STB_B]),
        .clrAll(wrMode),
        .inData(bInLatch),
        .ibf(ibfB),
        .obfN(obfBN),
        .intr(intrB)
    );

    // Port C lines taken over by the handshakes
    always_comb begin
        hsOutMask = `BYTE_ZERO;
        hsInMask = `BYTE_ZERO;
        hsVal = `BYTE_ZERO;
        if (aHsIn) begin
            hsOutMask[`PC_IBF_A] = 1'b1;
            hsOutMask[`PC_INTR_A] = 1'b1;
            hsInMask[`PC_STB_A] = 1'b1;
        end
        if (aHsOut) begin
            hsOutMask[`PC_OBF_A] = 1'b1;
            hsOutMask[`PC_INTR_A] = 1'b1;
            hsInMask[`PC_ACK_A] = 1'b1;
        end
        if (bMode == GM_STROBED) begin
            hsOutMask[`PC_BUF_B] = 1'b1;
            hsOutMask[`PC_INTR_B] = 1'b1;
            hsInMask[`PC_STB_B] = 1'b1;
        end
        hsVal[`PC_OBF_A] = obfAN;
        hsVal[`PC_IBF_A] = ibfA;
        hsVal[`PC_INTR_A] = intrA;
        hsVal[`PC_BUF_B] = bIn ? ibfB : obfBN;
        hsVal[`PC_INTR_B] = intrB;
    end

    // Per line of port C: direction, drive and read-back
    for (genvar i = 0; i < 8; i++) begin : gPc
        logic nibIn;
        assign nibIn = (i < `NIBBLE_W) ? portModeCtrl_q[`CW_CL_IN]
                                       : portModeCtrl_q[`CW_CU_IN];
        assign pcOe[i] = hsOutMask[i] | (~hsInMask[i] & ~nibIn);
        assign pcOut[i] = hsOutMask[i] ? hsVal[i] : pcLatch_q[i];
        assign pcRead[i] = hsOutMask[i] ? hsVal[i]
                         : (hsInMask[i] | ~nibIn) ? pcLatch_q[i]
                         : pcSync[i];
    end

    // Port A drive; bus mode drives only while ack is low
    assign paOut = aOut_q;
    assign paOe = (aMode == GM_BIDIR) ? {8{~pcSync[`PC_ACK_A]}}
                                      : {8{~aIn}};
    assign pbOut = bOut_q;
    assign pbOe = {8{~bIn}};

    // Data port read-back: live pins for basic-mode inputs, latches otherwise
    always_comb begin
        if (aMode == GM_BASIC) begin
            paRead = aIn ? paSync : aOut_q;
        end else begin
            paRead = aHsIn ? aInLatch : aOut_q;
        end
        if (bMode == GM_BASIC) begin
            pbRead = bIn ? pbSync : bOut_q;
        end else begin
            pbRead = bIn ? bInLatch : bOut_q;
        end
    end

    // Read data in the cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= `BYTE_ZERO;
        end else if (rdStb) begin
            case (addr)
                `OFS_PORT_A: rdData <= paRead;
                `OFS_PORT_B: rdData <= pbRead;
                `OFS_PORT_C: rdData <= pcRead;
                `OFS_IRQ_STAT: rdData <= {6'h00, irqStat_q};
                `OFS_IRQ_EN: rdData <= {6'h00, irqEn_q};
                default: rdData <= `BYTE_ZERO;
            endcase
        end
    end

    // Rising request lines become sticky status; set beats clear
    assign irqEvt = {intrB, intrA} & ~intrPrev_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            intrPrev_q <= '0;
            irqStat_q <= '0;
        end else begin
            intrPrev_q <= {intrB, intrA};
            if (wrStb && addr == `OFS_IRQ_CLR) begin
                irqStat_q <= (irqStat_q & ~wrData[`IRQ_W-1:0]) | irqEvt;
            end else begin
                irqStat_q <= irqStat_q | irqEvt;
            end
        end
    end

    // Interrupt enable register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqEn_q <= '0;
        end else if (wrStb && addr == `OFS_IRQ_EN) begin
            irqEn_q <= wrData[`IRQ_W-1:0];
        end
    end
    assign irq = |(irqStat_q & irqEn_q);

    mode_clear_a: assert property (wrMode |=> pcLatch_q == `BYTE_ZERO
        && portModeCtrl_q == $past(wrData))
        else $error("mode word did not load or clear latches");
    bit_set_a: assert property (wrBit |=>
        pcLatch_q[$past(bitIdx)] == $past(wrData[`BSR_VAL])
        && portModeCtrl_q == $past(portModeCtrl_q))
        else $error("bit set/reset missed its line");
    bit_alone_a: assert property (wrBit |=>
        ((pcLatch_q ^ $past(pcLatch_q)) & ~(8'h01 << $past(bitIdx)))
        == `BYTE_ZERO)
        else $error("bit set/reset disturbed other lines");
    live_input_a: assert property (aMode == GM_BASIC && aIn && rdA
        |=> rdData == $past(paSync))
        else $error("basic input read not the live pins");
    out_latch_a: assert property (aMode == GM_BASIC && !aIn && wrA
        && !wrMode |=> paOut == $past(wrData) && paOe == `BYTE_ONES)
        else $error("basic output not latched to pins");
    all_in_a: assert property (wrCtrl && wrData == `ALL_IN_WORD
        |=> paOe == `BYTE_ZERO && pbOe == `BYTE_ZERO
        && pcOe == `BYTE_ZERO)
        else $error("all-input word left a driver on");
    all_out_a: assert property (wrCtrl && wrData == `ALL_OUT_WORD
        |=> paOe == `BYTE_ONES && pbOe == `BYTE_ONES
        && pcOe == `BYTE_ONES)
        else $error("all-output word left a line undriven");
    split_dir_a: assert property (wrCtrl && wrData == `A_IN_WORD
        |=> paOe == `BYTE_ZERO && pbOe == `BYTE_ONES
        && pcOe == `BYTE_ONES)
        else $error("unit directions not independent");
    bus_write_a: assert property (aMode == GM_BIDIR && wrA && !wrMode
        |=> !pcOut[`PC_OBF_A] && pcOe[`PC_OBF_A])
        else $error("bus write did not flag buffer full");
endmodule // programmable_parallel_io
`default_nettype wire

// ### verification/pin_peripheral.sv
`timescale 1ns/100ps
`default_nettype none
module pin_peripheral (
    input wire logic mclk,
    input wire ppi_pkg::byte_t paOut,
    input wire ppi_pkg::byte_t paOe,
    input wire ppi_pkg::byte_t pbOut,
    input wire ppi_pkg::byte_t pbOe,
    input wire ppi_pkg::byte_t pcOut,
    input wire ppi_pkg::byte_t pcOe,
    output ppi_pkg::byte_t paIn,
    output ppi_pkg::byte_t pbIn,
    output ppi_pkg::byte_t pcIn
);
    import ppi_pkg::*;
    byte_t extA = 8'h00;
    byte_t extB = 8'h00;
    byte_t extC = 8'hFF;
    // Line level: the device where it drives, else the peripheral
    assign paIn = (paOe & paOut) | (~paOe & extA);
    assign pbIn = (pbOe & pbOut) | (~pbOe & extB);
    assign pcIn = (pcOe & pcOut) | (~pcOe & extC);
    // New levels from the peripheral, just after an edge
    task automatic setExt(input byte_t a, input byte_t b, input byte_t c);
        @(posedge mclk);
        extA <= a;
        extB <= b;
        extC <= c;
    endtask
    // Hold one port C line at a level
    task automatic level(input int bitNo, input logic v);
        @(posedge mclk);
        extC[bitNo] <= v;
    endtask
    // Strobe or ack pulse, data held across it, then idle high
    task automatic pulse(input int bitNo, input int lowCycles);
        @(posedge mclk);
        extC[bitNo] <= 1'b0;
        repeat (lowCycles) @(posedge mclk);
        extC[bitNo] <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
    endtask
endmodule // pin_peripheral
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppi_cfg.svh"
module tb;
    import ppi_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    byte_t wrData = 8'h00;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    byte_t rdData, paIn, paOut, paOe, pbIn, pbOut, pbOe, pcIn, pcOut, pcOe;
    logic irq;
    int mismatches = 0;
    int cmp_count = 0;
    byte_t w, d, e, ec, v;
    int idx;

    programmable_parallel_io i_dut (.mclk(mclk), .arst_n(arst_n),
        .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData(rdData), .paIn(paIn), .paOut(paOut), .paOe(paOe),
        .pbIn(pbIn), .pbOut(pbOut), .pbOe(pbOe), .pcIn(pcIn),
        .pcOut(pcOut), .pcOe(pcOe), .irq(irq));
    pin_peripheral i_per (.mclk(mclk), .paOut(paOut), .paOe(paOe),
        .pbOut(pbOut), .pbOe(pbOe), .pcOut(pcOut), .pcOe(pcOe),
        .paIn(paIn), .pbIn(pbIn), .pcIn(pcIn));

    // Free-running clock
    initial begin
        forever #4 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input byte_t g, input byte_t x);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [2:0] a, input byte_t dv);
        @(posedge mclk);
        addr <= a;
        wrData <= dv;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
        #1;
    endtask
    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output byte_t dv);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1;
        dv = rdData;
    endtask
    task automatic rdChk(input logic [2:0] a, input byte_t x);
        byte_t r;
        rd(a, r);
        chk(r, x);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Expected enables of A, B, C for a basic-mode word
    function automatic byte_t expOe(input byte_t cw, input int u);
        case (u)
            0: return cw[4] ? 8'h00 : 8'hFF;
            1: return cw[1] ? 8'h00 : 8'hFF;
            default: return {cw[3] ? 4'h0 : 4'hF, cw[0] ? 4'h0 : 4'hF};
        endcase
    endfunction
    // Expected pin level seen by a read
    function automatic byte_t mix(input byte_t oe, input byte_t o,
                                  input byte_t x);
        return (oe & o) | (~oe & x);
    endfunction

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        test_done();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h1e1f_310a));
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        idle(2);
        chk(paOe | pbOe | pcOe, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rdChk(`OFS_CTRL, 8'h00);
        rdChk(3'h7, 8'h00);
        // All sixteen basic layouts, twice, random data and pins
        for (int i = 0; i < 32; i++) begin
            w = {3'h4, i[3], i[2], 1'b0, i[1], i[0]};
            e = 8'($urandom);
            ec = 8'($urandom);
            i_per.setExt(e, ~e, ec);
            wr(`OFS_CTRL, w);
            chk(paOe, expOe(w, 0));
            chk(pbOe, expOe(w, 1));
            chk(pcOe, expOe(w, 2));
            d = 8'($urandom);
            v = 8'($urandom);
            wr(`OFS_PORT_A, d);
            wr(`OFS_PORT_B, ~d);
            wr(`OFS_PORT_C, v);
            chk(paOut & expOe(w, 0), d & expOe(w, 0));
            chk(pbOut & expOe(w, 1), ~d & expOe(w, 1));
            chk(pcOut & expOe(w, 2), v & expOe(w, 2));
            idle(3);
            rdChk(`OFS_PORT_A, mix(expOe(w, 0), d, e));
            rdChk(`OFS_PORT_B, mix(expOe(w, 1), ~d, ~e));
            rdChk(`OFS_PORT_C, mix(expOe(w, 2), v, ec));
        end
        // Single-line set and clear, ignored bits 6..4 randomised
        wr(`OFS_CTRL, `ALL_OUT_WORD);
        v = 8'($urandom);
        wr(`OFS_PORT_C, v);
        for (int i = 0; i < 16; i++) begin
            idx = $urandom % 8;
            w = {1'b0, 3'($urandom), 3'(idx), 1'($urandom)};
            v[idx] = w[0];
            wr(`OFS_CTRL, w);
            chk(pcOut, v);
            chk(paOe & pbOe & pcOe, 8'hFF);
        end
        // Strobed input on group A with request enabled, then masked
        d = 8'($urandom);
        i_per.setExt(d, 8'h00, 8'hFF);
        idle(4);
        wr(`OFS_CTRL, 8'hB0);
        wr(`OFS_CTRL, 8'h09);
        wr(`OFS_IRQ_EN, 8'h03);
        i_per.pulse(4, 1 + $urandom % 6);
        chk(pcOut & 8'h28, 8'h28);
        chk({7'h00, irq}, 8'h01);
        i_per.setExt(~d, 8'h00, 8'hFF);
        idle(3);
        rdChk(`OFS_PORT_A, d);
        idle(1);
        chk(pcOut & 8'h28, 8'h00);
        rdChk(`OFS_IRQ_STAT, 8'h01);
        wr(`OFS_IRQ_CLR, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(`OFS_IRQ_EN, 8'h00);
        i_per.pulse(4, 2);
        rdChk(`OFS_IRQ_STAT, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(`OFS_IRQ_CLR, 8'h03);
        // Strobed output on group B
        wr(`OFS_CTRL, 8'h84);
        wr(`OFS_CTRL, 8'h05);
        wr(`OFS_IRQ_EN, 8'h03);
        d = 8'($urandom);
        wr(`OFS_PORT_B, d);
        chk(pbOut, d);
        chk(pcOut & 8'h03, 8'h00);
        i_per.pulse(2, 1 + $urandom % 6);
        chk(pcOut & 8'h03, 8'h03);
        chk({7'h00, irq}, 8'h01);
        rdChk(`OFS_IRQ_STAT, 8'h02);
        wr(`OFS_PORT_B, ~d);
        chk(pcOut & 8'h03, 8'h00);
        wr(`OFS_IRQ_CLR, 8'h02);
        chk({7'h00, irq}, 8'h00);
        // Strobed output on group A with strobed input on group B
        e = 8'($urandom);
        i_per.setExt(8'h00, e, 8'hFF);
        wr(`OFS_CTRL, 8'hA6);
        wr(`OFS_CTRL, 8'h0D);
        wr(`OFS_CTRL, 8'h05);
        d = 8'($urandom);
        wr(`OFS_PORT_A, d);
        chk(paOut, d);
        chk(pcOut & 8'h88, 8'h00);
        i_per.pulse(6, 1 + $urandom % 6);
        chk(pcOut & 8'h88, 8'h88);
        chk({7'h00, irq}, 8'h01);
        rdChk(`OFS_IRQ_STAT, 8'h01);
        wr(`OFS_IRQ_CLR, 8'h01);
        i_per.pulse(2, 2);
        chk(pcOut & 8'h03, 8'h03);
        rdChk(`OFS_IRQ_STAT, 8'h02);
        rdChk(`OFS_PORT_B, e);
        chk(pcOut & 8'h03, 8'h00);
        wr(`OFS_IRQ_CLR, 8'h03);
        chk({7'h00, irq}, 8'h00);
        // Bidirectional bus on group A
        wr(`OFS_CTRL, 8'hC0);
        idle(4);
        chk(paOe, 8'h00);
        d = 8'($urandom);
        wr(`OFS_PORT_A, d);
        chk(paOut, d);
        i_per.level(6, 1'b0);
        idle(4);
        chk(paOe, 8'hFF);
        i_per.level(6, 1'b1);
        idle(4);
        chk(paOe, 8'h00);
        e = 8'($urandom);
        i_per.setExt(e, 8'h00, 8'hFF);
        idle(3);
        i_per.pulse(4, 2);
        i_per.setExt(~e, 8'h00, 8'hFF);
        idle(3);
        rdChk(`OFS_PORT_A, e);
        test_done();
    end
endmodule // tb
`default_nettype wire
